// >>> bsc_load_model.sv
// Behavioural model of the inductor, LED string and sense resistor
`timescale 1ns/1ps
module bsc_load_model (
  input wire logic core_clk,
  input wire logic high_side_switch,
  input wire logic switch_node_pulldown,
  input wire logic [7:0] on_len,
  input wire logic ocp_force,
  input wire logic neg_fast,
  output logic ocp_cmp,
  output logic neg_cur_cmp,
  output logic pwm_end_cmp,
  output logic skip_cur_cmp
);
  logic [7:0] on_cnt_ff;
  logic [5:0] pd_cnt_ff;
  always_ff @(posedge core_clk)
  begin
    on_cnt_ff <= high_side_switch ? on_cnt_ff + 8'h01 : 8'h00;
    pd_cnt_ff <= switch_node_pulldown ? pd_cnt_ff + 6'h01 : 6'h00;
  end
  // OCP, PWM-end and skip comparators read low while the switch is open: no current to sense
  assign ocp_cmp = ocp_force & high_side_switch;
  assign pwm_end_cmp = high_side_switch & (on_cnt_ff >= on_len);
  // Skip current is reached halfway through the nominal on-time
  assign skip_cur_cmp = high_side_switch & (on_cnt_ff >= {1'b0, on_len[7:1]});
  // Slow case lets the pulldown timeout win the race
  assign neg_cur_cmp = switch_node_pulldown & (pd_cnt_ff >= (neg_fast ? 6'h05 : 6'h1e));
endmodule // bsc_load_model

// >>> bsc_map.svh
// Timing constants and bit positions for the buck switch sequencing logic
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define BSC_CLK_MHZ 20
// ----------------------------------------------------------------
// Times as specified
// ----------------------------------------------------------------
`define BSC_DIM_TO_MS 42
`define BSC_BOOT_IDLE_MS 3
`define BSC_DISCH_US 530
`define BSC_PD_TIMEOUT_US 1
`define BSC_BLANK_NS 120
`define BSC_MAX_ON_US 12
// ----------------------------------------------------------------
// Derived cycle counts (least times round up, longest round down)
// ----------------------------------------------------------------
`define BSC_DIM_TO_CYC (`BSC_DIM_TO_MS * 1000 * `BSC_CLK_MHZ)
`define BSC_BOOT_IDLE_CYC (`BSC_BOOT_IDLE_MS * 1000 * `BSC_CLK_MHZ)
`define BSC_DISCH_CYC (`BSC_DISCH_US * `BSC_CLK_MHZ)
`define BSC_PD_TIMEOUT_CYC (`BSC_PD_TIMEOUT_US * `BSC_CLK_MHZ)
`define BSC_BLANK_CYC ((`BSC_BLANK_NS * `BSC_CLK_MHZ + 999) / 1000)
`define BSC_MAX_ON_CYC (`BSC_MAX_ON_US * `BSC_CLK_MHZ)
`define BSC_MIN_OFF_CYC 4
`define BSC_PERIOD_CYC 80
`define BSC_SKIP_MAX 7
// ----------------------------------------------------------------
// Bit positions of the synchronised comparator bundle
// ----------------------------------------------------------------
`define BSC_IN_EN 0
`define BSC_IN_GATE 1
`define BSC_IN_OCP 2
`define BSC_IN_NEG 3
`define BSC_IN_CLOW 4
`define BSC_IN_ISKIP 5
`define BSC_IN_PWM 6
`define BSC_IN_OT 7
`define BSC_IN_SSD 8
`define BSC_IN_W 9
`endif

// >>> bsc_pkg.sv
// Types shared by the buck switch sequencing logic
package bsc_pkg;
  typedef enum logic [2:0] {
    BSC_ST_OFF,
    BSC_ST_DISCH,
    BSC_ST_SS,
    BSC_ST_RUN,
    BSC_ST_THERM
  } bsc_state_e;
  typedef logic [2:0] bsc_skip_t;
endpackage

// >>> bsc_skip_cnt.sv
// Saturating overcurrent skip counter
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_skip_cnt (
  input wire logic core_clk,
  input wire logic sys_rst,
  bsc_skip_if.cnt sk
);
  import bsc_pkg::*;
  bsc_skip_t level_ff;
  bsc_skip_t remain_ff;

  // Level moves one step per blanking-end check
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || sk.clear)
      level_ff <= '0;
    else if (sk.eval && sk.ocp_hit && level_ff != 3'(`BSC_SKIP_MAX))
      level_ff <= level_ff + 3'h1;
    else if (sk.eval && !sk.ocp_hit && level_ff != 3'h0)
      level_ff <= level_ff - 3'h1;
  end

  // Remaining periods to skip before the next conduction
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || sk.clear)
      remain_ff <= '0;
    else if (sk.eval && sk.ocp_hit)
      remain_ff <= (level_ff == 3'(`BSC_SKIP_MAX)) ? level_ff : level_ff + 3'h1;
    // A clean check still skips, one period fewer, so the rate recovers in steps
    else if (sk.eval)
      remain_ff <= (level_ff == 3'h0) ? level_ff : level_ff - 3'h1;
    else if (sk.period_tick && remain_ff != 3'h0)
      remain_ff <= remain_ff - 3'h1;
  end

  assign sk.skip_busy = (remain_ff != 3'h0);
  assign sk.skip_level = level_ff;

  a_skip_saturate: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sk.eval && sk.ocp_hit && !sk.clear && level_ff == 3'h7) |=> level_ff == 3'h7)
    else $error("skip level left saturation");
  a_skip_floor: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sk.eval && !sk.ocp_hit && level_ff != 3'h0 && !sk.clear) |=>
    level_ff == $past(level_ff) - 3'h1)
    else $error("skip level did not step down");
endmodule // bsc_skip_cnt

// >>> bsc_skip_if.sv
// Link between the switch sequencer and the overcurrent skip counter
`timescale 1ns/1ps
interface bsc_skip_if;
  import bsc_pkg::*;
  logic eval;
  logic ocp_hit;
  logic period_tick;
  logic clear;
  logic skip_busy;
  bsc_skip_t skip_level;
  modport ctrl (output eval, output ocp_hit, output period_tick, output clear,
                input skip_busy, input skip_level);
  modport cnt (input eval, input ocp_hit, input period_tick, input clear,
               output skip_busy, output skip_level);
endinterface

// >>> bsc_switch_ctrl.sv
// Buck switch sequencing: dimming, soft-start, skip, boot refresh, OCP, thermal
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_switch_ctrl #(
  parameter logic [19:0] DIM_TO_CYC = 20'(`BSC_DIM_TO_CYC),
  parameter logic [15:0] BOOT_IDLE_CYC = 16'(`BSC_BOOT_IDLE_CYC),
  parameter logic [13:0] DISCH_CYC = 14'(`BSC_DISCH_CYC)
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic enable_in,
  input wire logic brightness_gate,
  input wire logic ocp_cmp,
  input wire logic neg_cur_cmp,
  input wire logic comp_low_cmp,
  input wire logic skip_cur_cmp,
  input wire logic pwm_end_cmp,
  input wire logic over_temp_cmp,
  input wire logic ss_done_cmp,
  output logic high_side_switch,
  output logic switch_node_pulldown,
  output logic comp_park,
  output logic osc_idle,
  output logic phase_sync_line,
  output logic ss_discharge,
  output logic ss_ramp
);
  import bsc_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [`BSC_IN_W-1:0] raw_in;
  logic [`BSC_IN_W-1:0] syn_in;
  logic en_s, gate_s, ocp_s, neg_s, clow_s, iskip_s, pwm_s, ot_s, ssd_s;

  assign raw_in = {ss_done_cmp, over_temp_cmp, pwm_end_cmp, skip_cur_cmp, comp_low_cmp,
                   neg_cur_cmp, ocp_cmp, brightness_gate, enable_in};

  bsc_sync #(.W(`BSC_IN_W)) bsc_sync_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  assign en_s = syn_in[`BSC_IN_EN];
  assign gate_s = syn_in[`BSC_IN_GATE];
  assign ocp_s = syn_in[`BSC_IN_OCP];
  assign neg_s = syn_in[`BSC_IN_NEG];
  assign clow_s = syn_in[`BSC_IN_CLOW];
  assign iskip_s = syn_in[`BSC_IN_ISKIP];
  assign pwm_s = syn_in[`BSC_IN_PWM];
  assign ot_s = syn_in[`BSC_IN_OT];
  assign ssd_s = syn_in[`BSC_IN_SSD];

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bsc_state_e state_ff;
  bsc_state_e nxt_state;
  logic [13:0] disch_cnt_ff;
  logic [19:0] dim_cnt_ff;
  logic [7:0] osc_cnt_ff;
  logic [7:0] on_cnt_ff;
  logic [15:0] off_cnt_ff;
  logic [4:0] pd_cnt_ff;
  logic hs_on_ff;
  logic pd_ff;
  logic idle_ff;
  logic sync_ff;
  logic park_ff;
  logic pskip_ff;
  logic switching;
  logic period_start;
  logic start_ok;
  logic blank_end;
  logic stop_now;
  logic max_on_hit;
  logic boot_hit;
  bsc_skip_if sk();

  bsc_skip_cnt bsc_skip_cnt_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sk(sk)
  );

  function automatic logic cnt_reached(input logic [19:0] cnt, input logic [19:0] lim);
    cnt_reached = (cnt >= lim);
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign switching = (state_ff == BSC_ST_SS) || (state_ff == BSC_ST_RUN);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      BSC_ST_OFF:
        if (en_s && gate_s)
          nxt_state = BSC_ST_DISCH;
      BSC_ST_DISCH:
        if (cnt_reached({6'h0, disch_cnt_ff}, {6'h0, DISCH_CYC}))
          nxt_state = BSC_ST_SS;
      BSC_ST_SS:
        if (ssd_s)
          nxt_state = BSC_ST_RUN;
      BSC_ST_RUN:
        nxt_state = BSC_ST_RUN;
      BSC_ST_THERM:
        if (!ot_s)
          nxt_state = BSC_ST_DISCH;
    endcase
    // Resume after a long dim must redo the whole ramp, not just re-enable
    if (switching && idle_ff && gate_s)
      nxt_state = BSC_ST_DISCH;
    if (ot_s && state_ff != BSC_ST_OFF)
      nxt_state = BSC_ST_THERM;
    if (!en_s)
      nxt_state = BSC_ST_OFF;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_ff <= BSC_ST_OFF;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || state_ff != BSC_ST_DISCH)
      disch_cnt_ff <= '0;
    else if (disch_cnt_ff != DISCH_CYC)
      disch_cnt_ff <= disch_cnt_ff + 14'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ss_discharge <= 1'b1;
      ss_ramp <= 1'b0;
    end
    else
    begin
      ss_discharge <= (nxt_state != BSC_ST_SS) && (nxt_state != BSC_ST_RUN);
      ss_ramp <= (nxt_state == BSC_ST_SS);
    end
  end

  // ----------------------------------------------------------------
  // Dimming: park, idle timeout
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || gate_s || !switching)
      dim_cnt_ff <= '0;
    else if (dim_cnt_ff != DIM_TO_CYC)
      dim_cnt_ff <= dim_cnt_ff + 20'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !en_s || gate_s)
      idle_ff <= 1'b0;
    else if (switching && cnt_reached(dim_cnt_ff, DIM_TO_CYC))
      idle_ff <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      park_ff <= 1'b0;
    else
      park_ff <= switching && !gate_s;
  end

  // ----------------------------------------------------------------
  // Oscillator and phase sync (half period shifted)
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || idle_ff || !en_s)
      osc_cnt_ff <= '0;
    else if (osc_cnt_ff == 8'(`BSC_PERIOD_CYC - 1))
      osc_cnt_ff <= '0;
    else
      osc_cnt_ff <= osc_cnt_ff + 8'h1;
  end

  assign period_start = en_s && !idle_ff && (osc_cnt_ff == 8'h0);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || idle_ff || !en_s)
      sync_ff <= 1'b0;
    else
      sync_ff <= (osc_cnt_ff >= 8'(`BSC_PERIOD_CYC / 2 - 1)) &&
                 (osc_cnt_ff != 8'(`BSC_PERIOD_CYC - 1));
  end

  // ----------------------------------------------------------------
  // High-side switch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !switching)
      pskip_ff <= 1'b0;
    // A period refused for low error level marks pulse-skip mode for the next pulse
    else if (period_start && clow_s)
      pskip_ff <= 1'b1;
    else if (stop_now)
      pskip_ff <= 1'b0;
  end

  assign start_ok = switching && gate_s && period_start && !sk.skip_busy && !clow_s
                    && !ot_s && (off_cnt_ff >= 16'(`BSC_MIN_OFF_CYC));
  // Overcurrent looked at only once blanking ends; earlier noise is ignored
  assign blank_end = hs_on_ff && (on_cnt_ff == 8'(`BSC_BLANK_CYC));
  assign max_on_hit = hs_on_ff && (on_cnt_ff == 8'(`BSC_MAX_ON_CYC - 1));
  // Minimum on-time equals the blanking window
  assign stop_now = hs_on_ff && (ot_s || !switching || max_on_hit || (blank_end && ocp_s)
                    || ((on_cnt_ff >= 8'(`BSC_BLANK_CYC)) &&
                        (!gate_s || pwm_s || (pskip_ff && iskip_s))));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      hs_on_ff <= 1'b0;
    else if (stop_now)
      hs_on_ff <= 1'b0;
    else if (start_ok && !pd_ff)
      hs_on_ff <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !hs_on_ff)
      on_cnt_ff <= '0;
    else
      on_cnt_ff <= on_cnt_ff + 8'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      off_cnt_ff <= 16'(`BSC_MIN_OFF_CYC);
    else if (hs_on_ff)
      off_cnt_ff <= '0;
    else if (off_cnt_ff != BOOT_IDLE_CYC)
      off_cnt_ff <= off_cnt_ff + 16'h1;
  end

  // ----------------------------------------------------------------
  // Switch-node pulldown
  // ----------------------------------------------------------------
  assign boot_hit = !hs_on_ff && en_s && (off_cnt_ff == BOOT_IDLE_CYC - 16'h1);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      pd_ff <= 1'b0;
    else if (max_on_hit || boot_hit)
      pd_ff <= 1'b1;
    else if (pd_ff && (neg_s || pd_cnt_ff == 5'(`BSC_PD_TIMEOUT_CYC - 1)))
      pd_ff <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !pd_ff)
      pd_cnt_ff <= '0;
    else
      pd_cnt_ff <= pd_cnt_ff + 5'h1;
  end

  // ----------------------------------------------------------------
  // Skip counter hookup
  // ----------------------------------------------------------------
  assign sk.eval = blank_end;
  assign sk.ocp_hit = ocp_s;
  assign sk.period_tick = period_start;
  assign sk.clear = !switching;

  assign high_side_switch = hs_on_ff;
  assign switch_node_pulldown = pd_ff;
  assign comp_park = park_ff;
  assign osc_idle = idle_ff;
  assign phase_sync_line = sync_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gate_no_start: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(hs_on_ff) |-> $past(gate_s))
    else $error("switch started with gate low");
  a_min_on_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($fell(hs_on_ff) && !$past(ot_s) && $past(switching)) |->
    $past(on_cnt_ff) >= 8'(`BSC_BLANK_CYC))
    else $error("switch cut before minimum on-time");
  a_park_dim: assert property (@(posedge core_clk) disable iff (sys_rst)
    (switching && !gate_s) |=> comp_park)
    else $error("error level not parked while dimmed");
  a_idle_long_low: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(idle_ff) |-> $past(dim_cnt_ff) == DIM_TO_CYC)
    else $error("oscillator idled too early");
  a_resume_softstart: assert property (@(posedge core_clk) disable iff (sys_rst)
    (idle_ff && gate_s && switching && en_s && !ot_s) |=> state_ff == BSC_ST_DISCH)
    else $error("no fresh soft-start after long dim");
  a_skip_hold_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clow_s && !hs_on_ff) |=> !hs_on_ff)
    else $error("switch started with low error level");
  a_boot_refresh: assert property (@(posedge core_clk) disable iff (sys_rst)
    boot_hit |=> pd_ff)
    else $error("bootstrap refresh pulldown missing");
  a_min_off_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(hs_on_ff) |-> $past(off_cnt_ff) >= 16'(`BSC_MIN_OFF_CYC))
    else $error("minimum off interval violated");
  a_max_on_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
    hs_on_ff |-> on_cnt_ff < 8'(`BSC_MAX_ON_CYC))
    else $error("on interval exceeded maximum");
  a_pd_timeout: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(pd_ff) && !max_on_hit && !boot_hit) |-> ##[1:20] !pd_ff)
    else $error("pulldown held past timeout");
  a_ocp_cut: assert property (@(posedge core_clk) disable iff (sys_rst)
    (blank_end && ocp_s) |=> !hs_on_ff)
    else $error("overcurrent did not end conduction");
  a_thermal_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    ot_s |=> !hs_on_ff ##0 (state_ff == BSC_ST_THERM || state_ff == BSC_ST_OFF))
    else $error("overtemperature did not shut down");
  a_disch_before_ramp: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_ff == BSC_ST_DISCH && nxt_state == BSC_ST_SS) |-> disch_cnt_ff == DISCH_CYC)
    else $error("discharge interval too short");
endmodule // bsc_switch_ctrl

// >>> bsc_switch_ctrl_tb.sv
// Self-checking testbench for the buck switch sequencing logic
`timescale 1ns/1ps
module bsc_switch_ctrl_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_in = 1'b0;
  logic brightness_gate = 1'b0;
  logic comp_low_cmp = 1'b0;
  logic over_temp_cmp = 1'b0;
  logic ss_done_cmp = 1'b0;
  logic ocp_force = 1'b0;
  logic neg_fast = 1'b1;
  logic [7:0] on_len = 8'h14;
  logic ocp_cmp, neg_cur_cmp, pwm_end_cmp, skip_cur_cmp;
  logic high_side_switch, switch_node_pulldown, comp_park, osc_idle;
  logic phase_sync_line, ss_discharge, ss_ramp;
  logic hs_q = 1'b0;
  logic pd_q = 1'b0;
  logic ps_q = 1'b0;
  logic [5:0] gh = 6'h00;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0, last_rise = 0, gap = 0, rise_cnt = 0, on_run = 0, on_last = 0;
  int off_run = 0, pd_run = 0, pd_last = 0, pd_rises = 0, ps_tog = 0, ss_cnt = 0;
  int k, n;
  integer seed = 32'h66c04fb8;

  always #25 core_clk = ~core_clk;

  // Shortened idle, refresh and discharge counts keep the run brief
  bsc_switch_ctrl #(
    .DIM_TO_CYC(20'h000c8),
    .BOOT_IDLE_CYC(16'h012c),
    .DISCH_CYC(14'h0032)
  ) bsc_switch_ctrl_inst (
    .core_clk, .sys_rst, .enable_in, .brightness_gate, .ocp_cmp, .neg_cur_cmp,
    .comp_low_cmp, .skip_cur_cmp, .pwm_end_cmp, .over_temp_cmp, .ss_done_cmp,
    .high_side_switch, .switch_node_pulldown, .comp_park, .osc_idle,
    .phase_sync_line, .ss_discharge, .ss_ramp
  );

  bsc_load_model bsc_load_model_inst (
    .core_clk, .high_side_switch, .switch_node_pulldown, .on_len, .ocp_force,
    .neg_fast, .ocp_cmp, .neg_cur_cmp, .pwm_end_cmp, .skip_cur_cmp
  );

  // Soft-start ramp reaches its reference 100 cycles after discharge ends
  always @(posedge core_clk)
  begin
    ss_cnt <= ss_discharge ? 0 : (ss_cnt < 100 ? ss_cnt + 1 : ss_cnt);
    ss_done_cmp <= (ss_cnt == 100);
  end

  // ----------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic wait_rises(input int cnt);
    int target;
    target = rise_cnt + cnt;
    n = 0;
    while (rise_cnt < target && n < 2000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(rise_cnt >= target, "switching stalled");
  endtask

  // Outputs are settled at the falling edge
  always @(negedge core_clk)
  begin
    cyc++;
    gh = {gh[4:0], brightness_gate};
    if (high_side_switch === 1'b1 && hs_q === 1'b0)
    begin
      gap = cyc - last_rise;
      last_rise = cyc;
      rise_cnt++;
      if (rise_cnt > 1) chk(off_run >= 4, "off interval too short");
      chk(gh !== 6'h00, "switching with gate low");
      on_run = 0;
    end
    if (high_side_switch === 1'b1)
    begin
      on_run++;
      off_run = 0;
    end
    else
    begin
      if (hs_q === 1'b1) on_last = on_run;
      off_run++;
    end
    if (switch_node_pulldown === 1'b1)
    begin
      if (pd_q !== 1'b1) pd_rises++;
      pd_run++;
    end
    else
    begin
      if (pd_q === 1'b1) pd_last = pd_run;
      pd_run = 0;
    end
    if (phase_sync_line !== ps_q) ps_tog++;
    if (enable_in && !sys_rst && gh[3:0] == 4'h0 && osc_idle === 1'b0)
      chk(comp_park === 1'b1, "error level not parked");
    hs_q = high_side_switch;
    pd_q = switch_node_pulldown;
    ps_q = phase_sync_line;
    if (cyc > 60000)
    begin
      miscompares++;
      $display("Error at %0t ns: run too long", $time);
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(high_side_switch === 1'b0 && ss_discharge === 1'b1, "bad reset state");
    chk(osc_idle === 1'b0 && ss_ramp === 1'b0, "bad reset state");
    @(posedge core_clk);
    enable_in <= 1'b1;
    brightness_gate <= 1'b1;
    repeat (40) @(posedge core_clk);
    chk(ss_discharge === 1'b1 && high_side_switch === 1'b0, "ramp too early");
    n = 0;
    while (ss_ramp !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= 8 && n <= 20, "discharge length wrong");
    wait_rises(3);
    k = ps_tog;
    repeat (100) @(posedge core_clk);
    chk(ps_tog > k, "sync line silent");
    // Random on-times and short dimming gaps
    for (int i = 0; i < 16; i++)
    begin
      on_len <= 8'h08 + {3'h0, 5'($random(seed))};
      wait_rises(2);
      chk(gap == 80, "period wrong");
      chk(on_last > on_len && on_last < on_len + 6, "on time wrong");
      brightness_gate <= 1'b0;
      repeat (20 + ($random(seed) & 127)) @(posedge core_clk);
      chk(osc_idle === 1'b0, "idle on short dim");
      brightness_gate <= 1'b1;
    end
    // Low dropout: maximum on interval and pulldown endings
    on_len <= 8'hff;
    neg_fast <= 1'b0;
    wait_rises(2);
    chk(on_last >= 239 && on_last <= 241, "max on wrong");
    chk(pd_last >= 19 && pd_last <= 21, "pulldown timeout wrong");
    neg_fast <= 1'b1;
    wait_rises(2);
    chk(pd_last >= 6 && pd_last <= 10, "pulldown kept on");
    // Gate falls just after turn-on, then stays low past the timeout
    wait_rises(1);
    brightness_gate <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(high_side_switch === 1'b1, "cut before min on");
    repeat (6) @(posedge core_clk);
    chk(high_side_switch === 1'b0, "not cut after gate fall");
    repeat (250) @(posedge core_clk);
    chk(osc_idle === 1'b1, "oscillator not idled");
    k = ps_tog;
    repeat (60) @(posedge core_clk);
    chk(ps_tog == k && phase_sync_line === 1'b0, "sync line active");
    brightness_gate <= 1'b1;
    on_len <= 8'h14;
    repeat (5) @(posedge core_clk);
    chk(ss_discharge === 1'b1, "no new soft-start");
    wait_rises(2);
    // Light load: no switching, one bootstrap refresh
    repeat (30) @(posedge core_clk);
    comp_low_cmp <= 1'b1;
    k = rise_cnt;
    n = pd_rises;
    repeat (450) @(posedge core_clk);
    chk(rise_cnt == k, "switched at low error level");
    chk(pd_rises == n + 1, "refresh count wrong");
    comp_low_cmp <= 1'b0;
    // Overcurrent: skip count climbs, saturates, then falls
    wait_rises(1);
    repeat (30) @(posedge core_clk);
    chk(on_last >= on_len / 2 + 2 && on_last <= on_len / 2 + 4, "skip current ignored");
    ocp_force <= 1'b1;
    wait_rises(1);
    for (int j = 1; j < 10; j++)
    begin
      wait_rises(1);
      chk(gap == 80 * ((j < 7 ? j : 7) + 1), "skip gap wrong");
      chk(on_last >= 3 && on_last <= 5, "overcurrent cut wrong");
    end
    repeat (10) @(posedge core_clk);
    ocp_force <= 1'b0;
    wait_rises(1);
    chk(gap == 640, "skip not saturated");
    wait_rises(1);
    chk(gap == 560, "skip not lowered");
    wait_rises(6);
    chk(gap == 80, "skip floor wrong");
    // Thermal shutdown and restart
    wait_rises(1);
    over_temp_cmp <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk(high_side_switch === 1'b0, "switch on when hot");
    k = rise_cnt;
    repeat (100) @(posedge core_clk);
    chk(rise_cnt == k, "switching in shutdown");
    over_temp_cmp <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(ss_discharge === 1'b1, "no soft-start after cooling");
    wait_rises(1);
    enable_in <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(high_side_switch === 1'b0 && phase_sync_line === 1'b0, "not off");
    stop_test();
  end
endmodule // bsc_switch_ctrl_tb

// >>> bsc_sync.sv
// Two-stage synchroniser for the asynchronous comparator inputs
`timescale 1ns/1ps
module bsc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // bsc_sync
